// File: logic/ref_mult_pkg.sv
// Purpose: Shared constants and carriers for the reference pulse multiplier
// Assumes: 32-bit register port, one word per register
// Notes:   Offsets are byte addresses; unmapped reads return zero
package ref_mult_pkg;

  // Register byte offsets
  localparam logic [7:0] ADDR_SWITCH_EN  = 8'h00;
  localparam logic [7:0] ADDR_FACTOR     = 8'h04;
  localparam logic [7:0] ADDR_SEL_MAP    = 8'h08;
  localparam logic [7:0] ADDR_ACK_MAP    = 8'h0c;
  localparam logic [7:0] ADDR_REALLOC_EN = 8'h10;
  localparam logic [7:0] ADDR_STATUS     = 8'h14;
  localparam logic [7:0] ADDR_POS_COUNT  = 8'h18;

  // Widths
  localparam int FACTOR_W = 7;
  localparam int MAP_W    = 4;
  localparam int ACKMAP_W = 2;
  localparam int NUM_SI   = 7;
  localparam int NUM_SO   = 3;
  localparam int INCR_W   = 8;
  localparam int COUNT_W  = 32;

  // Reset (factory) values
  localparam logic                RST_SWITCH_EN  = 1'b0;
  localparam logic [FACTOR_W-1:0] RST_FACTOR     = 7'h01;
  localparam logic [MAP_W-1:0]    RST_SEL_MAP    = 4'h8;
  localparam logic [ACKMAP_W-1:0] RST_ACK_MAP    = 2'h0;
  localparam logic                RST_REALLOC_EN = 1'b0;

  // Legal factor range
  localparam logic [FACTOR_W-1:0] FACTOR_MIN = 7'h01;
  localparam logic [FACTOR_W-1:0] FACTOR_MAX = 7'h63;

  // Select mapping codes
  localparam logic [MAP_W-1:0] MAP_DIRECT_LAST = 4'h6;
  localparam logic [MAP_W-1:0] MAP_FORCE_ON    = 4'h7;
  localparam logic [MAP_W-1:0] MAP_FORCE_OFF   = 4'h8;
  localparam logic [MAP_W-1:0] MAP_INV_FIRST   = 4'h9;

  // Status field positions
  localparam int ST_EN_BIT      = 0;
  localparam int ST_REALLOC_BIT = 1;
  localparam int ST_SELECT_BIT  = 2;
  localparam int ST_ACK_BIT     = 3;
  localparam int ST_SELMAP_LSB  = 4;
  localparam int ST_ACKMAP_LSB  = 8;

  // Configuration applied at control power-up
  typedef struct packed {
    logic                switch_en;
    logic                realloc_en;
    logic [MAP_W-1:0]    sel_map;
    logic [ACKMAP_W-1:0] ack_map;
  } boot_cfg_t;

  localparam boot_cfg_t RST_CFG = '{switch_en:  RST_SWITCH_EN,
                                    realloc_en: RST_REALLOC_EN,
                                    sel_map:    RST_SEL_MAP,
                                    ack_map:    RST_ACK_MAP};

  // Position increment handed to the position loop
  typedef struct packed {
    logic              valid;
    logic [INCR_W-1:0] amount;
  } pos_incr_t;

endpackage : ref_mult_pkg

// File: logic/mult_select_mapper.sv
// Purpose: Derives the multiplication select level from the sequence inputs
// Assumes: Inputs synchronous to the clock, active high at this point
// Notes:   Purely combinational; the caller registers the result
`timescale 1ns/1ps
module mult_select_mapper
  import ref_mult_pkg::*;
(
  input  wire logic [ref_mult_pkg::MAP_W-1:0]  map_i,
  input  wire logic [ref_mult_pkg::NUM_SI-1:0] seq_input_i,
  output logic                                 select_o
);

  logic [MAP_W-1:0] inv_idx;

  assign inv_idx = map_i - MAP_INV_FIRST;

  always_comb begin
    select_o = 1'b0;
    if (map_i <= MAP_DIRECT_LAST) begin
      select_o = seq_input_i[map_i[2:0]];
    end else if (map_i == MAP_FORCE_ON) begin
      select_o = 1'b1;
    end else if (map_i == MAP_FORCE_OFF) begin
      select_o = 1'b0;
    end else begin
      select_o = ~seq_input_i[inv_idx[2:0]];
    end
  end

endmodule : mult_select_mapper

// File: logic/ref_pulse_multiplier_select.sv
// Purpose: Reference pulse multiplication with selectable x1 or programmed factor
// Assumes: Single 100 MHz clock; pulses and sequence inputs synchronous to it
// Notes:   Power-up settings are staged and only applied on control power-up or in the first cycle after reset release
`timescale 1ns/1ps
module ref_pulse_multiplier_select
  import ref_mult_pkg::*;
(
  input  wire logic                              core_clk_i,
  input  wire logic                              reset_i,
  // Register port
  input  wire logic [7:0]                        reg_addr_i,
  input  wire logic [31:0]                       reg_wdata_i,
  input  wire logic                              reg_wr_i,
  input  wire logic                              reg_rd_i,
  output logic      [31:0]                       reg_rdata_o,
  // Control power has just been reapplied
  input  wire logic                              ctrl_power_up_i,
  // Reference pulses
  input  wire logic                              ref_pulse_i,
  input  wire logic                              opt_ref_pulse_i,
  input  wire logic [ref_mult_pkg::NUM_SI-1:0]   seq_input_i,
  // Results
  output ref_mult_pkg::pos_incr_t                pos_incr_o,
  output logic      [ref_mult_pkg::NUM_SO:1]     seq_output_o,
  output logic                                   mult_select_ack_out_o
);

  import ref_mult_pkg::*;

  // Staged settings written by software
  boot_cfg_t           staged_q;
  // Settings in force since the last power-up
  boot_cfg_t           active_q;
  logic                boot_load_q;
  logic [FACTOR_W-1:0] factor_q;
  logic                select_raw;
  logic                select_q;
  logic                mult_on;
  logic                ack_q;
  logic [COUNT_W-1:0]  pos_count_q;
  logic [INCR_W-1:0]   ref_amount;
  logic [INCR_W-1:0]   incr_d;
  pos_incr_t           incr_q;
  logic [31:0]         rdata_d;
  logic [31:0]         rdata_q;
  logic [31:0]         status;
  logic [FACTOR_W-1:0] wr_factor;

  assign wr_factor = reg_wdata_i[FACTOR_W-1:0];

  // Staged power-up settings; they steer nothing until the next power-up
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      staged_q <= RST_CFG;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        ADDR_SWITCH_EN:  staged_q.switch_en  <= reg_wdata_i[0];
        ADDR_REALLOC_EN: staged_q.realloc_en <= reg_wdata_i[0];
        ADDR_SEL_MAP:    staged_q.sel_map    <= reg_wdata_i[MAP_W-1:0];
        ADDR_ACK_MAP:    staged_q.ack_map    <= reg_wdata_i[ACKMAP_W-1:0];
        default: ;
      endcase
    end
  end

  // Load request raised by reset so the first cycle after release applies
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      boot_load_q <= 1'b1;
    end else begin
      boot_load_q <= 1'b0;
    end
  end

  // Applied only at power-up, never while running
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      active_q <= RST_CFG;
    end else if (boot_load_q || ctrl_power_up_i) begin
      active_q <= staged_q;
    end
  end

  // Factor is live; out-of-range writes are ignored so the value stays legal
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      factor_q <= RST_FACTOR;
    end else if (reg_wr_i && reg_addr_i == ADDR_FACTOR &&
                 wr_factor >= FACTOR_MIN && wr_factor <= FACTOR_MAX) begin
      factor_q <= wr_factor;
    end
  end

  mult_select_mapper u_mapper (
    .map_i       (active_q.sel_map),
    .seq_input_i (seq_input_i),
    .select_o    (select_raw)
  );

  // Without reallocation the select stays inactive
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      select_q <= 1'b0;
    end else begin
      select_q <= active_q.realloc_en & select_raw;
    end
  end

  // Selection may switch between pulses; a change mid-stream is the
  // controller's fault, so no attempt is made to rescale pending pulses
  assign mult_on = active_q.switch_en & select_q;

  always_comb begin
    ref_amount = '0;
    if (ref_pulse_i) begin
      if (mult_on) begin
        ref_amount = {{(INCR_W-FACTOR_W){1'b0}}, factor_q};
      end else begin
        ref_amount = 8'h01;
      end
    end
  end

  // Option board references always count one
  assign incr_d = ref_amount + {7'h00, opt_ref_pulse_i};

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      incr_q <= '0;
    end else begin
      incr_q.valid  <= ref_pulse_i | opt_ref_pulse_i;
      incr_q.amount <= incr_d;
    end
  end

  assign pos_incr_o = incr_q;

  // Running position total, readable by software
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      pos_count_q <= '0;
    end else if (incr_q.valid) begin
      pos_count_q <= pos_count_q + {{(COUNT_W-INCR_W){1'b0}}, incr_q.amount};
    end
  end

  // Acknowledge follows the multiplication actually applied to pulses
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= mult_on;
    end
  end

  assign mult_select_ack_out_o = ack_q;

  // Terminal routing of the acknowledge
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      seq_output_o <= '0;
    end else begin
      for (int i = 1; i <= NUM_SO; i++) begin
        seq_output_o[i] <= mult_on && (active_q.ack_map == ACKMAP_W'(i));
      end
    end
  end

  always_comb begin
    status                                       = '0;
    status[ST_EN_BIT]                            = active_q.switch_en;
    status[ST_REALLOC_BIT]                       = active_q.realloc_en;
    status[ST_SELECT_BIT]                        = select_q;
    status[ST_ACK_BIT]                           = ack_q;
    status[ST_SELMAP_LSB +: MAP_W]               = active_q.sel_map;
    status[ST_ACKMAP_LSB +: ACKMAP_W]            = active_q.ack_map;
  end

  // Staged values read back so software can check what the next boot applies
  always_comb begin
    rdata_d = '0;
    case (reg_addr_i)
      ADDR_SWITCH_EN:  rdata_d[0]               = staged_q.switch_en;
      ADDR_FACTOR:     rdata_d[FACTOR_W-1:0]    = factor_q;
      ADDR_SEL_MAP:    rdata_d[MAP_W-1:0]       = staged_q.sel_map;
      ADDR_ACK_MAP:    rdata_d[ACKMAP_W-1:0]    = staged_q.ack_map;
      ADDR_REALLOC_EN: rdata_d[0]               = staged_q.realloc_en;
      ADDR_STATUS:     rdata_d                  = status;
      ADDR_POS_COUNT:  rdata_d                  = pos_count_q;
      default:         rdata_d                  = '0;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      rdata_q <= '0;
    end else if (reg_rd_i) begin
      rdata_q <= rdata_d;
    end else begin
      rdata_q <= '0;
    end
  end

  assign reg_rdata_o = rdata_q;

endmodule : ref_pulse_multiplier_select

// File: bench/motion_ctrl_model.sv
// Purpose: Motion controller issuing position reference pulses
// Assumes: One pulse is one cycle high on ref_pulse_o
// Notes:   gap 0 sends pulses back to back; the line is low when idle
`timescale 1ns/1ps
module motion_ctrl_model (
  input  wire logic core_clk_i,
  input  wire logic reset_i,
  output logic      ref_pulse_o
);
  initial ref_pulse_o = 1'b0;

  // Pulse line stays at zero outside send, so selection changes are safe
  task automatic send(input int n, input int gap);
    for (int i = 0; i < n; i++) begin
      @(posedge core_clk_i);
      ref_pulse_o <= 1'b1;
      if (gap > 0) begin
        @(posedge core_clk_i);
        ref_pulse_o <= 1'b0;
        repeat (gap - 1) @(posedge core_clk_i);
      end
    end
    @(posedge core_clk_i);
    ref_pulse_o <= 1'b0;
  endtask : send
endmodule : motion_ctrl_model

// File: bench/ref_mult_chk.sv
// Purpose: Port-level assertions for the pulse multiplier
// Assumes: Single clock, asynchronous active-high reset
// Notes:   Bound into every instance of the top module
`timescale 1ns/1ps
module ref_mult_chk
  import ref_mult_pkg::*;
(
  input wire logic                     core_clk_i,
  input wire logic                     reset_i,
  input wire logic [7:0]               reg_addr_i,
  input wire logic                     reg_rd_i,
  input wire logic [31:0]              reg_rdata_o,
  input wire logic                     ctrl_power_up_i,
  input wire logic                     ref_pulse_i,
  input wire logic                     opt_ref_pulse_i,
  input wire ref_mult_pkg::pos_incr_t  pos_incr_o,
  input wire logic [ref_mult_pkg::NUM_SO:1] seq_output_o,
  input wire logic                     mult_select_ack_out_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);

  property p_valid; 1 |=> pos_incr_o.valid == $past(ref_pulse_i || opt_ref_pulse_i); endproperty
  property p_unity;
    ref_pulse_i && !opt_ref_pulse_i |=> mult_select_ack_out_o || pos_incr_o.amount == 8'h01;
  endproperty
  property p_opt; opt_ref_pulse_i && !ref_pulse_i |=> pos_incr_o.amount == 8'h01; endproperty
  property p_amount; pos_incr_o.valid |-> pos_incr_o.amount inside {[8'h01:8'h64]}; endproperty
  property p_so_one; 1 |-> $onehot0(seq_output_o); endproperty
  property p_so_ack; seq_output_o != 3'h0 |-> mult_select_ack_out_o; endproperty
  property p_rd_idle; !reg_rd_i |=> reg_rdata_o == 32'h0; endproperty
  property p_factor;
    reg_rd_i && reg_addr_i == ADDR_FACTOR |=> reg_rdata_o inside {[32'h01:32'h63]};
  endproperty
  // Skip the few cycles after power-up while the select path catches up
  property p_realloc;
    (!ctrl_power_up_i) [*4] ##0 (reg_rd_i && reg_addr_i == ADDR_STATUS) |=>
      !reg_rdata_o[ST_ACK_BIT] || (reg_rdata_o[ST_EN_BIT] && reg_rdata_o[ST_REALLOC_BIT]);
  endproperty

  a_valid: assert property (p_valid) else $error("increment valid mismatch");
  a_unity: assert property (p_unity) else $error("unity pulse not one");
  a_opt: assert property (p_opt) else $error("option pulse scaled");
  a_amount: assert property (p_amount) else $error("amount out of range");
  a_so_one: assert property (p_so_one) else $error("several outputs set");
  a_so_ack: assert property (p_so_ack) else $error("output without ack");
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  a_factor: assert property (p_factor) else $error("factor out of range");
  a_realloc: assert property (p_realloc) else $error("ack while disabled");

  c_mult: cover property (ref_pulse_i && mult_select_ack_out_o);
  c_so: cover property (seq_output_o != 3'h0);
  c_both: cover property (ref_pulse_i && opt_ref_pulse_i);
endmodule : ref_mult_chk

bind ref_pulse_multiplier_select ref_mult_chk u_ref_mult_chk (.core_clk_i, .reset_i,
  .reg_addr_i, .reg_rd_i, .reg_rdata_o, .ctrl_power_up_i, .ref_pulse_i, .opt_ref_pulse_i,
  .pos_incr_o, .seq_output_o, .mult_select_ack_out_o);

// File: bench/tb_ref_pulse_multiplier_select.sv
// Purpose: Self-checking bench for the reference pulse multiplier
// Assumes: Fixed latencies of register port and select path
// Notes:   A control power cycle is one ctrl_power_up_i pulse
`timescale 1ns/1ps
module tb_ref_pulse_multiplier_select;
  import ref_mult_pkg::*;
  logic              core_clk_i = 1'b0;
  logic              reset_i = 1'b1;
  logic [7:0]        reg_addr_i = 8'h00;
  logic [31:0]       reg_wdata_i = 32'h0;
  logic              reg_wr_i = 1'b0;
  logic              reg_rd_i = 1'b0;
  logic [31:0]       reg_rdata_o;
  logic              ctrl_power_up_i = 1'b0;
  logic              ref_pulse_i;
  logic              opt_ref_pulse_i = 1'b0;
  logic [NUM_SI-1:0] seq_input_i = 7'h00;
  pos_incr_t         pos_incr_o;
  logic [NUM_SO:1]   seq_output_o;
  logic              mult_select_ack_out_o;
  int                fail_count = 0;
  int                cmp_count = 0;
  int                k, p, b;
  logic              s;

  always #5 core_clk_i = ~core_clk_i;

  ref_pulse_multiplier_select u_ref_pulse_multiplier_select (.core_clk_i, .reset_i,
    .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .ctrl_power_up_i,
    .ref_pulse_i, .opt_ref_pulse_i, .seq_input_i, .pos_incr_o, .seq_output_o,
    .mult_select_ack_out_o);
  motion_ctrl_model u_motion_ctrl_model (.core_clk_i, .reset_i, .ref_pulse_o(ref_pulse_i));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic finish_test();
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : finish_test

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge core_clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    #1 check(reg_rdata_o, e);
  endtask : rd

  // Settle time covers the staged load plus the two-stage select path
  task automatic power_up();
    @(posedge core_clk_i);
    ctrl_power_up_i <= 1'b1;
    @(posedge core_clk_i);
    ctrl_power_up_i <= 1'b0;
    repeat (4) @(posedge core_clk_i);
  endtask : power_up

  function automatic logic [31:0] st(input logic en, re, sl, ac, input logic [3:0] sm,
                                     input logic [1:0] am);
    st = 32'h0;
    st[ST_EN_BIT] = en;
    st[ST_REALLOC_BIT] = re;
    st[ST_SELECT_BIT] = sl;
    st[ST_ACK_BIT] = ac;
    st[ST_SELMAP_LSB+:4] = sm;
    st[ST_ACKMAP_LSB+:2] = am;
  endfunction : st

  initial begin
    #500000;
    fail_count++;
    finish_test();
  end

  initial begin
    repeat (6) @(posedge core_clk_i);
    reset_i <= 1'b0;
    rd(ADDR_SWITCH_EN, 32'h0);
    rd(ADDR_FACTOR, 32'h1);
    rd(ADDR_SEL_MAP, 32'h8);
    rd(ADDR_ACK_MAP, 32'h0);
    rd(ADDR_REALLOC_EN, 32'h0);
    rd(8'h1c, 32'h0);
    wr(ADDR_FACTOR, 32'h63);
    wr(ADDR_FACTOR, 32'h64);
    wr(ADDR_FACTOR, 32'h0);
    rd(ADDR_FACTOR, 32'h63);
    wr(ADDR_SWITCH_EN, 32'h1);
    wr(ADDR_REALLOC_EN, 32'h1);
    wr(ADDR_SEL_MAP, 32'h7);
    wr(ADDR_ACK_MAP, 32'h2);
    rd(ADDR_STATUS, st(0, 0, 0, 0, 4'h8, 2'h0));
    power_up();
    rd(ADDR_STATUS, st(1, 1, 1, 1, 4'h7, 2'h2));
    check(32'(seq_output_o), 32'h2);
    u_motion_ctrl_model.send(3, 0);
    wr(ADDR_FACTOR, 32'h5);
    u_motion_ctrl_model.send(2, 3);
    @(posedge core_clk_i);
    opt_ref_pulse_i <= 1'b1;
    @(posedge core_clk_i);
    opt_ref_pulse_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    rd(ADDR_POS_COUNT, 32'd308);
    for (k = 0; k < 16; k++) begin
      b = (k < 9) ? k : k - 9;
      wr(ADDR_SEL_MAP, 32'(k));
      wr(ADDR_ACK_MAP, 32'(k % 4));
      power_up();
      for (p = 0; p < 2; p++) begin
        @(posedge core_clk_i);
        seq_input_i <= (p == 1) ? ~(7'h01 << b) : 7'h01 << b;
        repeat (3) @(posedge core_clk_i);
        // Codes 7 and 8 force the select regardless of the inputs
        s = (k == 7) || (k != 8 && ((k < 9) ^ (p == 1)));
        rd(ADDR_STATUS, st(1, 1, s, s, 4'(k), 2'(k % 4)));
        check(32'(seq_output_o), (s && k % 4 != 0) ? 32'h1 << (k % 4 - 1) : 32'h0);
        check(32'(mult_select_ack_out_o), 32'(s));
      end
    end
    wr(ADDR_REALLOC_EN, 32'h0);
    wr(ADDR_SEL_MAP, 32'h7);
    power_up();
    rd(ADDR_STATUS, st(1, 0, 0, 0, 4'h7, 2'h3));
    u_motion_ctrl_model.send(1, 0);
    repeat (2) @(posedge core_clk_i);
    rd(ADDR_POS_COUNT, 32'd309);
    // Select active but switching disabled: pulses must still count one
    wr(ADDR_SWITCH_EN, 32'h0);
    wr(ADDR_REALLOC_EN, 32'h1);
    power_up();
    rd(ADDR_STATUS, st(0, 1, 1, 0, 4'h7, 2'h3));
    check(32'(seq_output_o), 32'h0);
    check(32'(mult_select_ack_out_o), 32'h0);
    u_motion_ctrl_model.send(1, 0);
    repeat (2) @(posedge core_clk_i);
    rd(ADDR_POS_COUNT, 32'd310);
    finish_test();
  end
endmodule : tb_ref_pulse_multiplier_select
